/* File: design/pmc_pkg.sv */
// package: power management capability register layout and constants
`default_nettype none
package pmc_pkg;
	// register offsets relative to the capability base
	localparam logic [7:0] PMC_OFS_HEADER  = 8'h00;
	localparam logic [7:0] PMC_OFS_CAPS    = 8'h02;
	localparam logic [7:0] PMC_OFS_CTRL    = 8'h04;
	// header fields
	localparam logic [7:0] PMC_CAP_ID      = 8'h01;
	// capabilities word field positions
	localparam int PMC_CAP_WAKE_HI   = 15;
	localparam int PMC_CAP_WAKE_LO   = 11;
	localparam int PMC_CAP_ST2       = 10;
	localparam int PMC_CAP_ST1       = 9;
	localparam int PMC_CAP_AUX_HI    = 8;
	localparam int PMC_CAP_AUX_LO    = 6;
	localparam int PMC_CAP_INIT      = 5;
	localparam int PMC_CAP_WCLK      = 3;
	localparam int PMC_CAP_VER_HI    = 2;
	localparam int PMC_CAP_VER_LO    = 0;
	// capabilities fixed field values
	localparam logic [4:0] PMC_WAKE_SUPPORT = 5'h00;
	localparam logic [2:0] PMC_AUX_CURRENT  = 3'h0;
	localparam logic       PMC_STATE_SUPP   = 1'h0;
	localparam logic       PMC_WAKE_CLOCK   = 1'h0;
	localparam logic [2:0] PMC_VERSION_DEF  = 3'h3;
	localparam logic       PMC_INIT_DEF     = 1'h0;
	// control/status field positions
	localparam int PMC_CS_WSTAT      = 15;
	localparam int PMC_CS_SCALE_HI   = 14;
	localparam int PMC_CS_SCALE_LO   = 13;
	localparam int PMC_CS_SEL_HI     = 12;
	localparam int PMC_CS_SEL_LO     = 9;
	localparam int PMC_CS_WEN        = 8;
	localparam int PMC_CS_NORST      = 3;
	localparam int PMC_CS_PWR_HI     = 1;
	localparam int PMC_CS_PWR_LO     = 0;
	localparam logic PMC_NO_RESET_VAL = 1'h1;
	// power states
	typedef enum logic [1:0] {
		PMC_D0    = 2'h0,
		PMC_D1    = 2'h1,
		PMC_D2    = 2'h2,
		PMC_D3HOT = 2'h3
	} pmc_pstate_t;
	localparam pmc_pstate_t PMC_PWR_RESET = PMC_D0;
	// configuration access request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [1:0]  be;
		logic [15:0] wdata;
	} pmc_cfg_req_t;
	// function access gating outcome
	typedef struct packed {
		logic mem_en;
		logic io_en;
		logic irq_en;
	} pmc_gate_t;
endpackage
`default_nettype wire

/* File: design/pmc_gate.sv */
// module: gating of memory, i/o and interrupt paths by power state
`default_nettype none
module pmc_gate
	import pmc_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// current state and raw requests
	input  wire pmc_pstate_t i_state,
	input  wire logic        i_mem_req,
	input  wire logic        i_io_req,
	input  wire logic        i_irq,
	// gated outcome
	output pmc_gate_t        o_gate,
	output logic             o_mem_req,
	output logic             o_io_req,
	output logic             o_irq
);
	logic      d3_w;
	pmc_gate_t gate_nxt;
	pmc_gate_t gate_r;
	logic      mem_nxt;
	logic      io_nxt;
	logic      irq_nxt;
	logic      mem_r;
	logic      io_r;
	logic      irq_r;

	// compute the gated next values
	always_comb begin
		d3_w            = (i_state == PMC_D3HOT);
		gate_nxt.mem_en = !d3_w;
		gate_nxt.io_en  = !d3_w;
		gate_nxt.irq_en = !d3_w;
		mem_nxt         = i_mem_req && !d3_w;
		io_nxt          = i_io_req && !d3_w;
		irq_nxt         = i_irq && !d3_w;
	end

	// register the gated values
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			gate_r <= '{mem_en: 1'b1, io_en: 1'b1, irq_en: 1'b1};
			mem_r  <= 1'b0;
			io_r   <= 1'b0;
			irq_r  <= 1'b0;
		end else begin
			gate_r <= gate_nxt;
			mem_r  <= mem_nxt;
			io_r   <= io_nxt;
			irq_r  <= irq_nxt;
		end
	end

	assign o_gate    = gate_r;
	assign o_mem_req = mem_r;
	assign o_io_req  = io_r;
	assign o_irq     = irq_r;

	// no interrupt leaves one cycle after d3hot was seen
	property p_irq_block;
		@(posedge i_clk) disable iff (i_rst)
		(i_state == PMC_D3HOT) |=> !o_irq;
	endproperty
	a_irq_block: assert property (p_irq_block) else $error("irq passed in d3hot");

	// memory and i/o requests are cut in d3hot
	property p_space_block;
		@(posedge i_clk) disable iff (i_rst)
		(i_state == PMC_D3HOT) |=> (!o_mem_req && !o_io_req && !o_gate.mem_en);
	endproperty
	a_space_block: assert property (p_space_block) else $error("space open in d3hot");

	// a request outside d3hot passes one cycle later
	property p_pass;
		@(posedge i_clk) disable iff (i_rst)
		(i_state != PMC_D3HOT && i_mem_req) |=> o_mem_req;
	endproperty
	a_pass: assert property (p_pass) else $error("memory request lost outside d3hot");
endmodule
`default_nettype wire

/* File: design/pmc_regs.sv */
// module: power management capability registers with d3hot side effects
//
// Behaviour
// - Wake-event support field reads zero; wake signalling not offered.
// - Intermediate states D1 and D2 are reported unsupported.
// - Auxiliary current field reads zero.
// - Read-only bit tells whether device-specific initialisation is needed.
// - Wake clock bit reads zero.
// - Read-only version field declares power management revision 1.2 or later.
// - Wake status and wake enable bits read zero.
// - Data scale and data select fields read zero.
// - No-reset bit reads one; leaving D3hot keeps internal state.
// - Power state resets to D0; reads current state, writes request new.
// - Configuration reads and writes keep working in D3hot.
// - Memory and I/O register spaces are refused in D3hot.
// - All interrupts are blocked in D3hot.
// - Capability header low byte reads identifier 01h.
`default_nettype none
module pmc_regs
	import pmc_pkg::*;
#(
	parameter logic [7:0] NEXT_PTR    = 8'h00,
	parameter logic [2:0] VERSION     = PMC_VERSION_DEF,
	parameter logic       NEEDS_INIT  = PMC_INIT_DEF
)(
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// configuration access, offset relative to capability base
	input  wire pmc_cfg_req_t i_cfg,
	// function traffic to be gated
	input  wire logic         i_mem_req,
	input  wire logic         i_io_req,
	input  wire logic         i_irq,
	// configuration read answer
	output logic              o_cfg_ack,
	output logic [15:0]       o_cfg_rdata,
	// power state and gated traffic
	output pmc_pstate_t       o_state,
	output pmc_gate_t         o_gate,
	output logic              o_mem_req,
	output logic              o_io_req,
	output logic              o_irq
);
	pmc_pstate_t state_r;
	pmc_pstate_t state_nxt;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic        ack_r;
	logic        ack_nxt;
	logic [15:0] caps_w;
	logic [15:0] ctrl_w;
	logic [15:0] hdr_w;

	// fixed capabilities word
	always_comb begin
		caps_w = 16'h0000;
		caps_w[PMC_CAP_WAKE_HI:PMC_CAP_WAKE_LO] = PMC_WAKE_SUPPORT;
		caps_w[PMC_CAP_ST2] = PMC_STATE_SUPP;
		caps_w[PMC_CAP_ST1] = PMC_STATE_SUPP;
		caps_w[PMC_CAP_AUX_HI:PMC_CAP_AUX_LO] = PMC_AUX_CURRENT;
		caps_w[PMC_CAP_INIT] = NEEDS_INIT;
		caps_w[PMC_CAP_WCLK] = PMC_WAKE_CLOCK;
		caps_w[PMC_CAP_VER_HI:PMC_CAP_VER_LO] = VERSION;
	end

	// control/status word as seen by a read; unlisted bits stay zero
	always_comb begin
		ctrl_w = 16'h0000;
		ctrl_w[PMC_CS_WSTAT] = 1'b0;
		ctrl_w[PMC_CS_WEN] = 1'b0;
		ctrl_w[PMC_CS_SCALE_HI:PMC_CS_SCALE_LO] = 2'h0;
		ctrl_w[PMC_CS_SEL_HI:PMC_CS_SEL_LO] = 4'h0;
		ctrl_w[PMC_CS_NORST] = PMC_NO_RESET_VAL;
		ctrl_w[PMC_CS_PWR_HI:PMC_CS_PWR_LO] = state_r;
	end

	// capability header
	always_comb begin
		hdr_w = {NEXT_PTR, PMC_CAP_ID};
	end

	// next power state: only the low byte lane of the control word writes it
	always_comb begin
		state_nxt = state_r;
		if (i_cfg.wr && i_cfg.addr == PMC_OFS_CTRL && i_cfg.be[0]) begin
			state_nxt = pmc_pstate_t'(i_cfg.wdata[PMC_CS_PWR_HI:PMC_CS_PWR_LO]);
		end
	end

	// read mux and acknowledge; every other write is dropped
	always_comb begin
		ack_nxt   = i_cfg.rd || i_cfg.wr;
		rdata_nxt = 16'h0000;
		if (i_cfg.rd) begin
			case (i_cfg.addr)
				PMC_OFS_HEADER: rdata_nxt = hdr_w;
				PMC_OFS_CAPS:   rdata_nxt = caps_w;
				PMC_OFS_CTRL:   rdata_nxt = ctrl_w;
				default:        rdata_nxt = 16'h0000;
			endcase
		end
	end

	// register state; the d3hot to d0 move touches nothing else
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_r <= PMC_PWR_RESET;
			rdata_r <= 16'h0000;
			ack_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			rdata_r <= rdata_nxt;
			ack_r   <= ack_nxt;
		end
	end

	assign o_state     = state_r;
	assign o_cfg_rdata = rdata_r;
	assign o_cfg_ack   = ack_r;

	// gating of the function's spaces and interrupts
	pmc_gate u_gate (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_state   (state_r),
		.i_mem_req (i_mem_req),
		.i_io_req  (i_io_req),
		.i_irq     (i_irq),
		.o_gate    (o_gate),
		.o_mem_req (o_mem_req),
		.o_io_req  (o_io_req),
		.o_irq     (o_irq)
	);

	// capabilities read returns the fixed pattern
	property p_caps_read;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_CAPS) |=>
			(o_cfg_rdata[15:6] == 10'h000 && o_cfg_rdata[4:3] == 2'h0
			 && o_cfg_rdata[2:0] == VERSION && o_cfg_rdata[5] == NEEDS_INIT);
	endproperty
	a_caps_read: assert property (p_caps_read) else $error("capabilities wrong");

	// control read shows zeros, no-reset one, and the state
	property p_ctrl_read;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_CTRL) |=>
			(o_cfg_rdata[15:2] == 14'h0002 && o_cfg_rdata[1:0] == $past(state_r));
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control word wrong");

	// header low byte is the identifier
	property p_hdr_read;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_HEADER) |=> (o_cfg_rdata[7:0] == PMC_CAP_ID);
	endproperty
	a_hdr_read: assert property (p_hdr_read) else $error("header id wrong");

	// a state write lands one cycle later, also from d3hot
	property p_state_write;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.wr && i_cfg.addr == PMC_OFS_CTRL && i_cfg.be[0]) |=>
			(o_state == $past(i_cfg.wdata[1:0]));
	endproperty
	a_state_write: assert property (p_state_write) else $error("state not written");

	// writes elsewhere leave the state alone
	property p_state_hold;
		@(posedge i_clk) disable iff (i_rst)
		!(i_cfg.wr && i_cfg.addr == PMC_OFS_CTRL && i_cfg.be[0]) |=> $stable(o_state);
	endproperty
	a_state_hold: assert property (p_state_hold) else $error("state changed unasked");

	// configuration access is acknowledged in d3hot too
	property p_cfg_d3;
		@(posedge i_clk) disable iff (i_rst)
		(o_state == PMC_D3HOT && (i_cfg.rd || i_cfg.wr)) |=> o_cfg_ack;
	endproperty
	a_cfg_d3: assert property (p_cfg_d3) else $error("config refused in d3hot");

	// d3hot closes the i/o space from its second cycle on
	property p_d3_closed;
		@(posedge i_clk) disable iff (i_rst)
		(o_state == PMC_D3HOT) [*2] |-> (!o_gate.io_en && !o_io_req);
	endproperty
	a_d3_closed: assert property (p_d3_closed) else $error("io open in d3hot");

	// wake-event support field reads zero
	property p_wake_sup;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_CAPS) |=> (o_cfg_rdata[15:11] == 5'h00);
	endproperty
	a_wake_sup: assert property (p_wake_sup) else $error("wake support set");

	// intermediate states are reported absent
	property p_mid_states;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_CAPS) |=> (o_cfg_rdata[10:9] == 2'h0);
	endproperty
	a_mid_states: assert property (p_mid_states) else $error("d1 or d2 offered");

	// auxiliary current field reads zero
	property p_aux_cur;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_CAPS) |=> (o_cfg_rdata[8:6] == 3'h0);
	endproperty
	a_aux_cur: assert property (p_aux_cur) else $error("aux current set");

	// initialisation bit shows the chosen value
	property p_init_bit;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_CAPS) |=> (o_cfg_rdata[5] == NEEDS_INIT);
	endproperty
	a_init_bit: assert property (p_init_bit) else $error("init bit wrong");

	// wake clock bit reads zero
	property p_wake_clk;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_CAPS) |=> !o_cfg_rdata[3];
	endproperty
	a_wake_clk: assert property (p_wake_clk) else $error("wake clock set");

	// version field shows the fixed value
	property p_version;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_CAPS) |=> (o_cfg_rdata[2:0] == VERSION);
	endproperty
	a_version: assert property (p_version) else $error("version wrong");

	// reserved capabilities bit reads zero
	property p_caps_rsvd;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_CAPS) |=> !o_cfg_rdata[4];
	endproperty
	a_caps_rsvd: assert property (p_caps_rsvd) else $error("caps reserved set");

	// wake status and wake enable read zero
	property p_wake_bits;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_CTRL) |=> (!o_cfg_rdata[15] && !o_cfg_rdata[8]);
	endproperty
	a_wake_bits: assert property (p_wake_bits) else $error("wake bits set");

	// data scale and data select read zero
	property p_data_flds;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_CTRL) |=> (o_cfg_rdata[14:9] == 6'h00);
	endproperty
	a_data_flds: assert property (p_data_flds) else $error("data fields set");

	// no-reset bit reads one
	property p_norst_bit;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_CTRL) |=> o_cfg_rdata[3];
	endproperty
	a_norst_bit: assert property (p_norst_bit) else $error("no-reset bit clear");

	// reserved control bits read zero
	property p_ctrl_rsvd;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_CTRL) |=>
			(o_cfg_rdata[7:4] == 4'h0 && !o_cfg_rdata[2]);
	endproperty
	a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("ctrl reserved set");

	// header high byte is the next pointer
	property p_hdr_next;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr == PMC_OFS_HEADER) |=> (o_cfg_rdata[15:8] == NEXT_PTR);
	endproperty
	a_hdr_next: assert property (p_hdr_next) else $error("next pointer wrong");

	// offsets outside the three words read zero
	property p_unmapped;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.rd && i_cfg.addr != PMC_OFS_HEADER && i_cfg.addr != PMC_OFS_CAPS
		 && i_cfg.addr != PMC_OFS_CTRL) |=> (o_cfg_rdata == 16'h0000);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	// acknowledge and read data stand one cycle only
	property p_ack_idle;
		@(posedge i_clk) disable iff (i_rst)
		!(i_cfg.rd || i_cfg.wr) |=> (!o_cfg_ack && o_cfg_rdata == 16'h0000);
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("answer without request");

	// a write is answered with empty read data
	property p_wr_answer;
		@(posedge i_clk) disable iff (i_rst)
		(i_cfg.wr && !i_cfg.rd) |=> (o_cfg_ack && o_cfg_rdata == 16'h0000);
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer wrong");

	// reset brings the state back to d0 and drops the answer
	property p_rst_state;
		@(posedge i_clk)
		i_rst |=> (o_state == PMC_D0 && !o_cfg_ack);
	endproperty
	a_rst_state: assert property (p_rst_state) else $error("reset state wrong");

	// leaving d3hot by a state write lands in d0 and is answered
	property p_d3_exit;
		@(posedge i_clk) disable iff (i_rst)
		(o_state == PMC_D3HOT && i_cfg.wr && i_cfg.addr == PMC_OFS_CTRL && i_cfg.be[0]
		 && i_cfg.wdata[1:0] == 2'h0) |=> (o_state == PMC_D0 && o_cfg_ack);
	endproperty
	a_d3_exit: assert property (p_d3_exit) else $error("d3hot exit wrong");
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// testbench: power management capability registers and d3hot gating
`default_nettype none
module tb import pmc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic         i_clk     = 1'h0;
	logic         i_rst     = 1'h1;
	pmc_cfg_req_t i_cfg     = '0;
	logic         i_mem_req = 1'h0;
	logic         i_io_req  = 1'h0;
	logic         i_irq     = 1'h0;
	logic         o_cfg_ack;
	logic [15:0]  o_cfg_rdata;
	pmc_pstate_t  o_state;
	pmc_gate_t    o_gate;
	logic         o_mem_req;
	logic         o_io_req;
	logic         o_irq;
	int           fail_count = 0;
	int           num_checks = 0;
	logic [15:0]  wd;
	logic [1:0]   be;
	logic [1:0]   cur;

	pmc_regs dut (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_cfg       (i_cfg),
		.i_mem_req   (i_mem_req),
		.i_io_req    (i_io_req),
		.i_irq       (i_irq),
		.o_cfg_ack   (o_cfg_ack),
		.o_cfg_rdata (o_cfg_rdata),
		.o_state     (o_state),
		.o_gate      (o_gate),
		.o_mem_req   (o_mem_req),
		.o_io_req    (o_io_req),
		.o_irq       (o_irq)
	);

	// 50 mhz clock
	always #10 i_clk = ~i_clk;

	// compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// verdict and end of run
	task automatic final_report();
		if (fail_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// expected capabilities word: all optional features absent
	function automatic logic [15:0] exp_caps();
		return {5'h00, 1'h0, 1'h0, 3'h0, PMC_INIT_DEF, 1'h0, 1'h0, PMC_VERSION_DEF};
	endfunction

	// expected control/status word for a given state
	function automatic logic [15:0] exp_ctrl(input logic [1:0] s);
		return {12'h000, 1'h1, 1'h0, s};
	endfunction

	// one config read, held until the next falling edge; request left standing
	task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp, input string what);
		i_cfg = '{1'h1, 1'h0, a, 2'h3, 16'h0000};
		@(negedge i_clk);
		check("ack", {15'h0000, o_cfg_ack}, 16'h0001);
		check(what, o_cfg_rdata, exp);
	endtask

	// one config write
	task automatic wr_reg(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
		i_cfg = '{1'h0, 1'h1, a, b, d};
		@(negedge i_clk);
		check("ack", {15'h0000, o_cfg_ack}, 16'h0001);
		check("wr rdata", o_cfg_rdata, 16'h0000);
	endtask

	// enter a state, then push random function traffic through the gate
	task automatic gate_run(input logic [1:0] s);
		logic       blk;
		logic [2:0] drv;
		blk = (s == 2'h3);
		wr_reg(8'h04, 2'h1, {14'h0000, s});
		i_cfg = '0;
		@(negedge i_clk);
		check("ack idle", {15'h0000, o_cfg_ack}, 16'h0000);
		check("rdata idle", o_cfg_rdata, 16'h0000);
		@(negedge i_clk);
		for (int k = 0; k < 16; k++) begin
			drv = 3'($urandom());
			{i_mem_req, i_io_req, i_irq} = drv;
			@(negedge i_clk);
			check("gated", {13'h0000, o_mem_req, o_io_req, o_irq}, {13'h0000, drv & {3{~blk}}});
			check("gate", {13'h0000, o_gate}, {13'h0000, {3{~blk}}});
		end
	endtask

	// main sequence
	initial begin
		void'($urandom(28522));
		repeat (10) @(negedge i_clk);
		i_rst = 1'h0;
		rd_reg(8'h00, 16'h0001, "header");
		rd_reg(8'h02, exp_caps(), "caps");
		rd_reg(8'h04, exp_ctrl(2'h0), "ctrl");
		cur = 2'h0;
		for (int n = 0; n < 24; n++) begin
			wd = 16'($urandom());
			wr_reg(8'h00, 2'h3, wd);
			wr_reg(8'h02, 2'h3, ~wd);
			if (n < 4) begin
				wd[1:0] = 2'(n);
			end
			be = (n < 4) ? 2'h1 : 2'($urandom());
			if (be[0]) begin
				cur = wd[1:0];
			end
			wr_reg(8'h04, be, wd);
			check("state", {14'h0000, o_state}, {14'h0000, cur});
			rd_reg(8'h04, exp_ctrl(cur), "ctrl");
			rd_reg(8'h02, exp_caps(), "caps");
			rd_reg(8'h00, 16'h0001, "header");
			rd_reg(8'($urandom_range(6, 255)), 16'h0000, "unmapped");
		end
		gate_run(2'h3);
		rd_reg(8'h02, exp_caps(), "caps d3");
		rd_reg(8'h04, exp_ctrl(2'h3), "ctrl d3");
		gate_run(2'h0);
		rd_reg(8'h04, exp_ctrl(2'h0), "ctrl d0");
		gate_run(2'h2);
		gate_run(2'h3);
		// reset in mid-run from d3hot
		i_rst = 1'h1;
		@(negedge i_clk);
		i_rst = 1'h0;
		check("state rst", {14'h0000, o_state}, 16'h0000);
		check("gate rst", {13'h0000, o_gate}, 16'h0007);
		check("gated rst", {13'h0000, o_mem_req, o_io_req, o_irq}, 16'h0000);
		rd_reg(8'h04, exp_ctrl(2'h0), "ctrl rst");
		final_report();
	end

	// watchdog against a hung run
	initial begin
		repeat (4000) @(posedge i_clk);
		fail_count++;
		final_report();
	end
endmodule
`default_nettype wire
